// ---- rtl/qbsram_pkg.sv ----
// Shared constants and types for the burst SRAM port logic and controller
package qbsram_pkg;
    localparam int ADDR_W        = 18;          // One address per burst
    localparam int WORD_W        = 18;
    localparam int PAIR_W        = 2 * WORD_W;  // K word low, K# word high
    localparam int LANE_W        = 9;
    localparam int LANES         = 8;           // Byte lanes per burst line
    localparam int PAIR_LANES    = LANES / 2;
    localparam int LINE_W        = LANES * LANE_W;
    localparam int MEM_DEPTH     = 1 << ADDR_W;
    localparam int REF_PERIOD_NS = 50;
    localparam int DLL_STOP_NS   = 30;
    localparam int DLL_STOP_CYC  =
        (DLL_STOP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    // Margin for the two-flop sampling of a running link clock
    localparam int STOP_LIMIT    = DLL_STOP_CYC + 2;
    localparam int DLL_LOCK_CYC  = 2048;
    localparam int CAL_PERIOD    = 1024;
    localparam int CNT_W         = 12;
    localparam int CAL_W         = 10;
    localparam int GAP_W         = 2;
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(DLL_LOCK_CYC - 1);
    localparam logic [CAL_W-1:0] CAL_LAST  = CAL_W'(CAL_PERIOD - 1);
    localparam logic [GAP_W-1:0] STOP_LAST = GAP_W'(STOP_LIMIT);
    // Idle levels of the link outputs of the controller
    localparam logic             SEL_IDLE_N = 1'h1;
    localparam logic [3:0]       BWS_IDLE_N = 4'hf;
    localparam logic             DLL_ON_N   = 1'h1;

    // Write burst progress: address taken, first pair held, commit
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_PAIR0,
        WR_COMMIT
    } qbs_wr_t;
endpackage : qbsram_pkg

// ---- rtl/qbs_link_if.sv ----
// Link between the burst SRAM port logic and its memory controller
`timescale 1ns/100ps
interface qbs_link_if;
    logic                          k;
    logic                          k_n;
    logic                          read_port_select_n;
    logic                          write_port_select_n;
    logic [qbsram_pkg::ADDR_W-1:0] addr;
    logic [qbsram_pkg::PAIR_W-1:0] d;
    logic [3:0]                    byte_lane_write_select_n;
    logic                          loop_disable_n;
    logic [qbsram_pkg::PAIR_W-1:0] q;
    logic                          q_oe;
    logic [qbsram_pkg::PAIR_W-1:0] q_bus;
    logic [1:0]                    read_valid_flag;
    logic                          echo_clock_out;
    logic                          echo_clock_out_n;

    // A floating read bus is seen as zero; q_oe marks when it is driven
    assign q_bus = q_oe ? q : '0;

    modport device (
        input  k, k_n, read_port_select_n, write_port_select_n, addr, d,
        input  byte_lane_write_select_n, loop_disable_n,
        output q, q_oe, read_valid_flag, echo_clock_out, echo_clock_out_n
    );
    modport ctrl (
        output k, k_n, read_port_select_n, write_port_select_n, addr, d,
        output byte_lane_write_select_n, loop_disable_n,
        input  q_bus, q_oe, read_valid_flag, echo_clock_out,
        input  echo_clock_out_n
    );
endinterface : qbs_link_if

// ---- rtl/qbs_ctrl_end.sv ----
// Memory controller end: makes the link clock and issues bursts
`timescale 1ns/100ps
module qbs_ctrl_end (
    input  wire logic                          REF_CLK_I,
    input  wire logic                          RST_N_I,
    input  wire logic                          CMD_VALID_I,
    input  wire logic                          CMD_WRITE_I,
    input  wire logic [qbsram_pkg::ADDR_W-1:0] CMD_ADDR_I,
    input  wire logic [qbsram_pkg::LINE_W-1:0] CMD_WDATA_I,
    input  wire logic [qbsram_pkg::LANES-1:0]  CMD_BYTE_EN_I,
    input  wire logic                          LEGACY_MODE_I,
    output logic                               CMD_READY_O,
    output logic                               RD_VALID_O,
    output logic [qbsram_pkg::PAIR_W-1:0]      RD_DATA_O,
    qbs_link_if.ctrl                           LINK
);
    typedef struct packed {
        logic                          k;
        logic                          k_n;
        logic                          rps_n;
        logic                          wps_n;
        logic [qbsram_pkg::ADDR_W-1:0] addr;
        logic [qbsram_pkg::PAIR_W-1:0] d;
        logic [3:0]                    bws_n;
        logic                          dis_n;
        qbsram_pkg::qbs_wr_t           wr_st;
        logic [qbsram_pkg::LINE_W-1:0] wbuf;
        logic [qbsram_pkg::LANES-1:0]  wbe;
        logic                          last_rd;
        logic                          last_wr;
        logic [qbsram_pkg::CNT_W-1:0]  lock_cnt;
        logic                          locked;
        logic                          rd_valid;
        logic [qbsram_pkg::PAIR_W-1:0] rd_data;
    } qbs_cst_t;

    localparam int PW = qbsram_pkg::PAIR_W;

    qbs_cst_t cs_reg;
    qbs_cst_t cs_next;
    logic     fall;
    logic     lock_ok;
    logic     ready;

    // Link outputs change on the K fall, half a cycle ahead of K rise
    assign fall    = cs_reg.k;
    assign lock_ok = LEGACY_MODE_I | cs_reg.locked;
    // No same-kind start on two K rises running, one start per cycle
    assign ready   = fall & lock_ok &
                     (CMD_WRITE_I ? ~cs_reg.last_wr : ~cs_reg.last_rd);

    always_comb begin
        cs_next          = cs_reg;
        cs_next.k        = ~cs_reg.k;
        cs_next.k_n      = cs_reg.k;
        cs_next.rd_valid = 1'h0;
        if (fall) begin
            cs_next.rps_n   = qbsram_pkg::SEL_IDLE_N;
            cs_next.wps_n   = qbsram_pkg::SEL_IDLE_N;
            cs_next.bws_n   = qbsram_pkg::BWS_IDLE_N;
            cs_next.last_rd = 1'h0;
            cs_next.last_wr = 1'h0;
            cs_next.dis_n   = ~LEGACY_MODE_I;
            // Write data follows its address on the next two K rises
            unique case (cs_reg.wr_st)
                qbsram_pkg::WR_PAIR0: begin
                    cs_next.d     = cs_reg.wbuf[PW-1:0];
                    cs_next.bws_n = ~cs_reg.wbe[3:0];
                    cs_next.wr_st = qbsram_pkg::WR_COMMIT;
                end
                qbsram_pkg::WR_COMMIT: begin
                    cs_next.d     = cs_reg.wbuf[2*PW-1:PW];
                    cs_next.bws_n = ~cs_reg.wbe[7:4];
                    cs_next.wr_st = qbsram_pkg::WR_IDLE;
                end
                qbsram_pkg::WR_IDLE: ;
                default: cs_next.wr_st = qbsram_pkg::WR_IDLE;
            endcase
            if (CMD_VALID_I && ready) begin
                cs_next.addr = CMD_ADDR_I;
                if (CMD_WRITE_I) begin
                    cs_next.wps_n   = 1'h0;
                    cs_next.last_wr = 1'h1;
                    cs_next.wbuf    = CMD_WDATA_I;
                    cs_next.wbe     = CMD_BYTE_EN_I;
                    cs_next.wr_st   = qbsram_pkg::WR_PAIR0;
                end else begin
                    cs_next.rps_n   = 1'h0;
                    cs_next.last_rd = 1'h1;
                end
            end
            // Outside legacy mode, device timing is trusted only after the loop has locked
            if (LEGACY_MODE_I) begin
                cs_next.lock_cnt = '0;
                cs_next.locked   = 1'h0;
            end else if (!cs_reg.locked) begin
                cs_next.lock_cnt = cs_reg.lock_cnt + 1'h1;
                cs_next.locked   = (cs_reg.lock_cnt == qbsram_pkg::LOCK_LAST);
            end
            // Capture by the valid flag, so either latency is handled
            if (LINK.q_oe && LINK.read_valid_flag[0]) begin
                cs_next.rd_valid = 1'h1;
                cs_next.rd_data  = LINK.q_bus;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cs_reg       <= '0;
            cs_reg.k_n   <= 1'h1;
            cs_reg.rps_n <= qbsram_pkg::SEL_IDLE_N;
            cs_reg.wps_n <= qbsram_pkg::SEL_IDLE_N;
            cs_reg.bws_n <= qbsram_pkg::BWS_IDLE_N;
            cs_reg.dis_n <= qbsram_pkg::DLL_ON_N;
        end else begin
            cs_reg <= cs_next;
        end
    end

    assign CMD_READY_O                   = ready;
    assign RD_VALID_O                    = cs_reg.rd_valid;
    assign RD_DATA_O                     = cs_reg.rd_data;
    assign LINK.k                        = cs_reg.k;
    assign LINK.k_n                      = cs_reg.k_n;
    assign LINK.read_port_select_n       = cs_reg.rps_n;
    assign LINK.write_port_select_n      = cs_reg.wps_n;
    assign LINK.addr                     = cs_reg.addr;
    assign LINK.d                        = cs_reg.d;
    assign LINK.byte_lane_write_select_n = cs_reg.bws_n;
    assign LINK.loop_disable_n           = cs_reg.dis_n;
endmodule : qbs_ctrl_end

// ---- rtl/qbs_sram_end.sv ----
// Burst SRAM port logic: read and write pipelines, array, loop states
`timescale 1ns/100ps

module qbs_sram_end (
    input  wire logic  REF_CLK_I,
    input  wire logic  RST_N_I,
    input  wire logic  IMPEDANCE_REFERENCE_I,
    output logic       DLL_LOCKED_O,
    output logic       DRIVE_CAL_O,
    output logic       CAL_UPDATE_O,
    qbs_link_if.device LINK
);
    localparam int AW = qbsram_pkg::ADDR_W;
    localparam int PW = qbsram_pkg::PAIR_W;
    localparam int LW = qbsram_pkg::LINE_W;
    localparam int NW = qbsram_pkg::LANE_W;
    localparam int PL = qbsram_pkg::PAIR_LANES;

    // Link clock domain state
    typedef struct packed {
        logic [2:0]                   rd_v;
        logic [2:0][AW-1:0]           rd_a;
        logic                         last_rd;
        logic                         last_wr;
        qbsram_pkg::qbs_wr_t          wr_st;
        logic [AW-1:0]                wr_a;
        logic [PW-1:0]                wb_d;
        logic [PL-1:0]                wb_be;
        logic [PW-1:0]                q;
        logic                         q_oe;
        logic [1:0]                   flag;
        logic                         k_tog;
        logic [qbsram_pkg::CNT_W-1:0] lock_cnt;
        logic                         locked;
        logic [qbsram_pkg::CAL_W-1:0] cal_cnt;
        logic                         cal_val;
        logic                         cal_upd;
        logic                         zq_s1;
        logic                         zq_s2;
        logic                         req_s1;
        logic                         req_s2;
        logic                         ack;
    } qbs_kst_t;

    // Reference clock domain state: watches the link clock for stops
    typedef struct packed {
        logic                         tog_s1;
        logic                         tog_s2;
        logic                         tog_d;
        logic [qbsram_pkg::GAP_W-1:0] gap;
        logic                         seen;
        logic                         req;
        logic                         ack_s1;
        logic                         ack_s2;
    } qbs_rst_t;

    qbs_kst_t        ks_reg;
    qbs_kst_t        ks_next;
    qbs_rst_t        rs_reg;
    qbs_rst_t        rs_next;
    logic [LW-1:0]   mem [0:qbsram_pkg::MEM_DEPTH-1];
    logic [LW-1:0]   wr_line;
    logic [2*PL-1:0] wr_be;

    // Lay the held first pair over a line for read-after-write
    function automatic logic [LW-1:0] qbs_fwd(
        input logic [LW-1:0] line,
        input logic [PW-1:0] wd,
        input logic [PL-1:0] be,
        input logic          hit
    );
        logic [LW-1:0] r;
        r = line;
        for (int j = 0; j < PL; j++) begin
            if (hit && be[j]) begin
                r[j*NW +: NW] = wd[j*NW +: NW];
            end
        end
        return r;
    endfunction : qbs_fwd

    // Pipeline slot that holds a burst due out now: first or second pair
    function automatic logic [1:0] qbs_idx(
        input logic legacy,
        input logic second
    );
        return {1'h0, ~legacy} + {1'h0, second};
    endfunction : qbs_idx

    always_comb begin
        logic          legacy;
        logic          rd_go;
        logic          wr_go;
        logic          out0;
        logic          out1;
        logic          hit;
        logic [1:0]    i0;
        logic [1:0]    i1;
        logic [AW-1:0] ra;
        logic [LW-1:0] line;
        ks_next = ks_reg;
        legacy  = ~LINK.loop_disable_n;
        // Selects are looked at only here, on the K rise
        rd_go   = ~LINK.read_port_select_n & ~ks_reg.last_rd;
        // A read always wins unless it was itself just refused
        wr_go   = ~LINK.write_port_select_n & ~ks_reg.last_wr
                  & ~rd_go;
        i0      = qbs_idx(legacy, 1'h0);
        i1      = qbs_idx(legacy, 1'h1);
        out0    = ks_reg.rd_v[i0];
        out1    = ks_reg.rd_v[i1];
        // Alternating reads keep the two pairs of bursts apart
        ra      = out0 ? ks_reg.rd_a[i0] : ks_reg.rd_a[i1];
        hit     = (ks_reg.wr_st == qbsram_pkg::WR_COMMIT) &&
                  (ks_reg.wr_a == ra);
        line    = qbs_fwd(mem[ra], ks_reg.wb_d, ks_reg.wb_be, hit);

        // Read age pipeline runs on regardless of later deselects
        ks_next.rd_v    = {ks_reg.rd_v[1:0], rd_go};
        ks_next.rd_a    = {ks_reg.rd_a[1:0], LINK.addr};
        ks_next.last_rd = rd_go;
        ks_next.last_wr = wr_go;
        ks_next.q_oe    = out0 | out1;
        if (out0) begin
            ks_next.q = line[PW-1:0];
        end else if (out1) begin
            ks_next.q = line[LW-1:PW];
        end else begin
            ks_next.q = '0;
        end
        // Bit 1 is the K# half: high when data is due on the next rise
        ks_next.flag[0] = out0 | out1;
        ks_next.flag[1] = ks_next.rd_v[i0] | ks_next.rd_v[i1];

        // Write side takes inputs only while a burst is in flight
        unique case (ks_reg.wr_st)
            qbsram_pkg::WR_PAIR0: begin
                ks_next.wb_d  = LINK.d;
                ks_next.wb_be = ~LINK.byte_lane_write_select_n;
                ks_next.wr_st = qbsram_pkg::WR_COMMIT;
            end
            qbsram_pkg::WR_COMMIT: ks_next.wr_st = qbsram_pkg::WR_IDLE;
            qbsram_pkg::WR_IDLE:   ;
            default:               ks_next.wr_st = qbsram_pkg::WR_IDLE;
        endcase
        if (wr_go) begin
            ks_next.wr_st = qbsram_pkg::WR_PAIR0;
            ks_next.wr_a  = LINK.addr;
        end

        // Echo toggle doubles as the activity beacon for stop detection
        ks_next.k_tog = ~ks_reg.k_tog;

        // Loop lock count; restarted by a clock stop or by disabling
        ks_next.req_s1 = rs_reg.req;
        ks_next.req_s2 = ks_reg.req_s1;
        ks_next.ack    = ks_reg.req_s2;
        if (ks_reg.req_s2 || legacy) begin
            ks_next.lock_cnt = '0;
            ks_next.locked   = 1'h0;
        end else if (!ks_reg.locked) begin
            ks_next.lock_cnt = ks_reg.lock_cnt + 1'h1;
            ks_next.locked   = (ks_reg.lock_cnt == qbsram_pkg::LOCK_LAST);
        end

        // Impedance reference is a pin level: two flops, then sampled
        ks_next.zq_s1   = IMPEDANCE_REFERENCE_I;
        ks_next.zq_s2   = ks_reg.zq_s1;
        ks_next.cal_upd = (ks_reg.cal_cnt == qbsram_pkg::CAL_LAST);
        ks_next.cal_cnt = ks_reg.cal_cnt + 1'h1;
        if (ks_next.cal_upd) begin
            ks_next.cal_val = ks_reg.zq_s2;
        end
    end

    always_ff @(posedge LINK.k or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ks_reg <= '0;
        end else begin
            ks_reg <= ks_next;
        end
    end

    // Commit the full line at the rise that brings the second pair
    assign wr_line = {LINK.d, ks_reg.wb_d};
    assign wr_be   = {~LINK.byte_lane_write_select_n, ks_reg.wb_be};

    // Array has no reset; per-lane enables keep masked lanes intact
    always_ff @(posedge LINK.k) begin
        if (ks_reg.wr_st == qbsram_pkg::WR_COMMIT) begin
            for (int j = 0; j < 2 * PL; j++) begin
                if (wr_be[j]) begin
                    mem[ks_reg.wr_a][j*NW +: NW] <= wr_line[j*NW +: NW];
                end
            end
        end
    end

    // A stopped link clock is seen from the reference clock and
    // handed across by a four-phase request and acknowledge
    always_comb begin
        rs_next        = rs_reg;
        rs_next.tog_s1 = ks_reg.k_tog;
        rs_next.tog_s2 = rs_reg.tog_s1;
        rs_next.tog_d  = rs_reg.tog_s2;
        rs_next.ack_s1 = ks_reg.ack;
        rs_next.ack_s2 = rs_reg.ack_s1;
        if (rs_reg.tog_s2 != rs_reg.tog_d) begin
            rs_next.gap  = '0;
            rs_next.seen = 1'h0;
        end else if (rs_reg.gap != qbsram_pkg::STOP_LAST) begin
            rs_next.gap = rs_reg.gap + 1'h1;
        end
        if (rs_reg.gap == qbsram_pkg::STOP_LAST && !rs_reg.seen &&
            !rs_reg.req && !rs_reg.ack_s2) begin
            rs_next.req  = 1'h1;
            rs_next.seen = 1'h1;
        end else if (rs_reg.req && rs_reg.ack_s2) begin
            rs_next.req = 1'h0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rs_reg <= '0;
        end else begin
            rs_reg <= rs_next;
        end
    end

    assign LINK.q                = ks_reg.q;
    assign LINK.q_oe             = ks_reg.q_oe;
    assign LINK.read_valid_flag  = ks_reg.flag;
    assign LINK.echo_clock_out   = ks_reg.k_tog;
    assign LINK.echo_clock_out_n = ~ks_reg.k_tog;
    assign DLL_LOCKED_O          = ks_reg.locked;
    assign DRIVE_CAL_O           = ks_reg.cal_val;
    assign CAL_UPDATE_O          = ks_reg.cal_upd;
endmodule : qbs_sram_end

// ---- sim/qbs_link_asserts.sv ----
// Concurrent checks on the link between controller and burst SRAM
`timescale 1ns/100ps
module qbs_link_asserts (
    input wire logic                          k,
    input wire logic                          RST_N_I,
    input wire logic                          read_port_select_n,
    input wire logic                          write_port_select_n,
    input wire logic                          loop_disable_n,
    input wire logic [qbsram_pkg::PAIR_W-1:0] q,
    input wire logic                          q_oe,
    input wire logic [1:0]                    read_valid_flag,
    input wire logic                          echo_clock_out,
    input wire logic                          echo_clock_out_n
);
    default clocking cb @(posedge k); endclocking
    default disable iff (!RST_N_I);
    logic       rd_prev_reg;
    logic [1:0] alive_reg;
    wire        rd_take = !read_port_select_n && !rd_prev_reg;
    // Reads on the rise after a taken read are dropped, so track takes
    always_ff @(posedge k or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_prev_reg <= 1'b0;
            alive_reg   <= 2'h0;
        end else begin
            rd_prev_reg <= rd_take;
            alive_reg   <= {alive_reg[0], 1'b1};
        end
    end
    a_read_burst: assert property (rd_take && loop_disable_n |-> ##2
        read_valid_flag[1] ##1 q_oe && read_valid_flag == 2'h3
        ##1 q_oe && read_valid_flag[0]) else $error("read burst timing");
    a_oe_cause: assert property ($rose(q_oe) |-> (loop_disable_n ?
        $past(rd_take, 3) : $past(rd_take, 2)))
        else $error("data driven without a taken read");
    a_burst_len: assert property ($fell(q_oe) |-> $past(q_oe, 2))
        else $error("read burst shorter than two pairs");
    a_idle_zero: assert property (!q_oe |-> q == '0)
        else $error("read data not quiet while floating");
    a_flag_tie: assert property (q_oe == read_valid_flag[0])
        else $error("valid flag and data drive disagree");
    a_echo_toggle: assert property (alive_reg[1] |->
        echo_clock_out != $past(echo_clock_out)) else $error("echo stuck");
    a_echo_pair: assert property (
        echo_clock_out_n == !echo_clock_out)
        else $error("echo clocks not complementary");
    a_one_start: assert property (read_port_select_n ||
        write_port_select_n) else $error("both ports started together");
    a_write_space: assert property (!write_port_select_n |=>
        write_port_select_n) else $error("writes on consecutive rises");
    a_read_space: assert property (!read_port_select_n |=>
        read_port_select_n) else $error("reads on consecutive rises");
    c_read: cover property (rd_take && loop_disable_n);
    c_read_legacy: cover property (rd_take && !loop_disable_n);
    c_write: cover property (!write_port_select_n);
    c_data: cover property ($rose(q_oe));
endmodule : qbs_link_asserts

// ---- sim/tb_quad_rate_burst_sram_port_logic.sv ----
// Self-checking bench: controller and burst SRAM joined on one link
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    err_total++; $display("[FAIL] %0t value mismatch", $time); end end
module tb_quad_rate_burst_sram_port_logic;
    logic                          ref_clk = 1'b0;
    logic                          rst_n;
    logic                          cmd_valid = 1'b0;
    logic                          cmd_write = 1'b0;
    logic                          legacy = 1'b0;
    logic                          zq = 1'b0;
    logic [qbsram_pkg::ADDR_W-1:0] cmd_addr = '0;
    logic [qbsram_pkg::LINE_W-1:0] cmd_wdata = '0;
    logic [qbsram_pkg::LANES-1:0]  cmd_be = '0;
    wire                           ready, rd_valid, locked, dcal, cal_upd;
    wire  [qbsram_pkg::PAIR_W-1:0] rd_data;
    logic [71:0]                   mem [int];
    logic [35:0]                   exp_q [$];
    int                            err_total = 0;
    int                            n_tests = 0;
    int                            seed = 75;
    always #25 ref_clk = ~ref_clk;
    qbs_link_if qbs_link_if_i ();
    qbs_ctrl_end qbs_ctrl_end_i (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
        .CMD_VALID_I(cmd_valid), .CMD_WRITE_I(cmd_write),
        .CMD_ADDR_I(cmd_addr), .CMD_WDATA_I(cmd_wdata), .CMD_BYTE_EN_I(cmd_be),
        .LEGACY_MODE_I(legacy), .CMD_READY_O(ready), .RD_VALID_O(rd_valid),
        .RD_DATA_O(rd_data), .LINK(qbs_link_if_i));
    qbs_sram_end qbs_sram_end_i (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
        .IMPEDANCE_REFERENCE_I(zq), .DLL_LOCKED_O(locked),
        .DRIVE_CAL_O(dcal), .CAL_UPDATE_O(cal_upd), .LINK(qbs_link_if_i));
    qbs_link_asserts qbs_link_asserts_i (.k(qbs_link_if_i.k),
        .RST_N_I(rst_n), .read_port_select_n(qbs_link_if_i.read_port_select_n),
        .write_port_select_n(qbs_link_if_i.write_port_select_n),
        .loop_disable_n(qbs_link_if_i.loop_disable_n), .q(qbs_link_if_i.q),
        .q_oe(qbs_link_if_i.q_oe),
        .read_valid_flag(qbs_link_if_i.read_valid_flag),
        .echo_clock_out(qbs_link_if_i.echo_clock_out),
        .echo_clock_out_n(qbs_link_if_i.echo_clock_out_n));
    task automatic final_report;
        $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Valid stays high across calls so back-to-back requests stay legal
    task automatic issue(input logic wr, input int a, input logic [71:0] wd,
                         input logic [7:0] be);
        int   n;
        logic ok;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr  <= 18'(a);
        cmd_wdata <= wd;
        cmd_be    <= be;
        do begin
            @(negedge ref_clk);
            ok = ready;
            @(posedge ref_clk);
            n++;
        end while (ok !== 1'b1 && n < 6000);
        if (ok !== 1'b1) begin
            err_total++;
            final_report();
        end
        for (int j = 0; j < 8; j++) begin
            if (wr && be[j])
                mem[a][9*j +: 9] = wd[9*j +: 9];
        end
        if (!wr) begin
            exp_q.push_back(mem[a][35:0]);
            exp_q.push_back(mem[a][71:36]);
        end
    endtask : issue
    task automatic drain;
        cmd_valid <= 1'b0;
        for (int n = 0; n < 100 && exp_q.size() != 0; n++)
            @(posedge ref_clk);
        `CHK(exp_q.size(), 0)
        if (exp_q.size() != 0)
            final_report();
    endtask : drain
    // Rising edges of the calibration pulse should be 1024 k cycles apart
    task automatic cal_check;
        int   n, m;
        logic prev;
        n = 0;
        m = 0;
        prev = 1'b1;
        for (int i = 0; i < 5000 && m < 2; i++) begin
            @(negedge ref_clk);
            if (m == 1)
                n++;
            if (cal_upd === 1'b1 && !prev)
                m++;
            prev = cal_upd;
        end
        `CHK(n, 2 * qbsram_pkg::CAL_PERIOD)
        `CHK(dcal, zq)
        if (m < 2)
            final_report();
    endtask : cal_check
    // Every returned pair is compared with the reference array
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1 && exp_q.size() == 0)
            `CHK(1'b1, 1'b0)
        else if (rd_valid === 1'b1)
            `CHK(rd_data, exp_q.pop_front())
    end
    initial begin
        rst_n <= 1'b0; // X to 0 is a falling edge for all four async resets
        repeat (4) @(posedge ref_clk);
        `CHK(qbs_link_if_i.q_oe, 1'b0)
        rst_n <= 1'b1;
        zq    <= 1'b1;
        for (int pass = 0; pass < 2; pass++) begin
            if (pass == 1) begin
                rst_n  <= 1'b0;
                legacy <= 1'b1;
                repeat (4) @(posedge ref_clk);
                `CHK(qbs_link_if_i.q_oe, 1'b0)
                rst_n <= 1'b1;
            end
            // Full write then an immediate read of it exercises forwarding in the legacy pass
            for (int i = 0; i < 4; i++) begin
                issue(1'b1, i * 5, 72'({$random(seed), $random(seed),
                    $random(seed)}), 8'hff);
                issue(1'b0, i * 5, '0, '0);
            end
            for (int i = 0; i < 12; i++) begin
                issue(1'b1, ($random(seed) & 3) * 5, 72'({$random(seed),
                    $random(seed), $random(seed)}), 8'($random(seed)));
                issue(1'b0, ($random(seed) & 3) * 5, '0, '0);
                issue(1'b0, ($random(seed) & 3) * 5, '0, '0);
            end
            drain();
            // Legacy mode keeps the loop off, so it must not report lock
            `CHK(locked, pass == 0)
            if (pass == 0) begin
                zq <= 1'b0; // A new level must reach the drive setting
                cal_check();
            end
            $display("Test pass %0d finished", pass);
        end
        final_report();
    end
endmodule : tb_quad_rate_burst_sram_port_logic
